// file: design/lcc_pkg.sv
// Package for the link capability, control and status register bank.
// Assumes an APB slave on a 100 MHz core clock with an async low reset.
package lcc_pkg;

  // Byte addresses of the registers on the APB window
  localparam logic [11:0] LCC_OFS_CAP  = 12'h0EC; // Link capabilities
  localparam logic [11:0] LCC_OFS_LCS  = 12'h0F0; // Control low, status high
  localparam logic [11:0] LCC_OFS_IST  = 12'h0F4; // Event status, sticky
  localparam logic [11:0] LCC_OFS_ICLR = 12'h0F8; // Event clear, write-only
  localparam logic [11:0] LCC_OFS_IEN  = 12'h0FC; // Event enable

  // Fixed link figures
  localparam logic [3:0] LCC_SPEED_2G5   = 4'h1;  // Only defined speed code
  localparam logic [5:0] LCC_WIDTH_X1    = 6'h01; // Single lane
  localparam logic [7:0] LCC_PORT_NUM    = 8'h00; // Not implemented

  // Reset values of the autoloadable capability fields
  localparam logic [1:0] LCC_ASPM_SUP_RST = 2'h3; // L0s and L1 entry
  localparam logic [2:0] LCC_L0S_LAT_RST  = 3'h3; // 256 ns to < 512 ns
  localparam logic [2:0] LCC_L1_LAT_RST   = 3'h0; // 16 us to < 32 us

  // Control field positions
  localparam int LCC_CTL_CCLK  = 6; // Common clock configuration
  localparam int LCC_CTL_ESYNC = 7; // Extended synch

  // Event bits of the interrupt status layout
  localparam int LCC_EV_TERR = 0; // Training error seen
  localparam int LCC_EV_TDONE = 1; // Training finished
  localparam int LCC_EV_LOAD = 2; // Autoload applied
  localparam int LCC_EV_N    = 3;

  // Exit sequence counts for the transmitter
  localparam logic [12:0] LCC_FTS_EXT = 13'h1000; // 4096 with extended synch
  localparam logic [12:0] LCC_FTS_NOM = 13'h0080; // Plain default, normal
  localparam logic [10:0] LCC_TS1_EXT = 11'h400;  // 1024 with extended synch
  localparam logic [10:0] LCC_TS1_NOM = 11'h010;  // Plain default, normal

  // Values delivered by the external EEPROM autoload
  typedef struct packed {
    logic [1:0] aspm_sup; // Power-state support
    logic [2:0] l0s_lat;  // L0s exit latency code
    logic [2:0] l1_lat;   // L1 exit latency code
  } lcc_ee_t;

  // Whole state of the bank
  typedef struct packed {
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    lcc_ee_t             cap;       // Autoloadable capability fields
    logic [1:0]          aspm_ctl;  // Power-state entry control
    logic                cclk;      // Common clock setting
    logic                esync;     // Extended synch setting
    logic [5:0]          width;     // Negotiated width
    logic                terr;      // Training error status
    logic                ltrain;    // Training in progress
    logic [LCC_EV_N-1:0] istat;     // Sticky events
    logic [LCC_EV_N-1:0] ien;       // Event enables
    logic                irq;
    logic                rx_l0s_en; // Receiver L0s entry permit
    logic [12:0]         fts_cnt;
    logic [10:0]         ts1_cnt;
  } lcc_state_t;

  localparam lcc_state_t LCC_ST_RST = '{
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
    cap: '{aspm_sup: LCC_ASPM_SUP_RST, l0s_lat: LCC_L0S_LAT_RST,
           l1_lat: LCC_L1_LAT_RST},
    aspm_ctl: 2'h0, cclk: 1'b0, esync: 1'b0, width: LCC_WIDTH_X1,
    terr: 1'b0, ltrain: 1'b0, istat: 3'h0, ien: 3'h0, irq: 1'b0,
    rx_l0s_en: 1'b0, fts_cnt: LCC_FTS_NOM, ts1_cnt: LCC_TS1_NOM};

endpackage

// file: design/lcc_regs.sv
// Link capability, control and status register bank with APB access.
// Assumes an APB3/APB4 master on pclk, link-layer strobes synchronous
// to pclk, and an EEPROM loader that pulses ee_load_valid once per load.
`timescale 1ns/1ps

module lcc_regs (
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // EEPROM autoload
  input  wire logic                ee_load_valid,
  input  wire lcc_pkg::lcc_ee_t    ee_load,
  // Link layer status
  input  wire logic                train_active,
  input  wire logic                train_fail,
  input  wire logic                link_l0,
  input  wire logic [5:0]          neg_width,
  // Link layer control
  output logic                     tx_l0s_en,
  output logic                     tx_l1_en,
  output logic                     rx_l0s_en,
  output logic                     common_clk,
  output logic [12:0]              fts_count,
  output logic [10:0]              ts1_count,
  // Interrupt
  output logic                     irq
);
  import lcc_pkg::*;

  lcc_state_t          st_q;     // Registered state
  lcc_state_t          st_d;     // Next state
  logic                acc;      // First access cycle, answer is built
  logic                done;     // Completion edge, writes take effect
  logic                wr;       // Accepted write at completion
  logic                hit_cap;  // Address decodes
  logic                hit_lcs;
  logic                hit_ist;
  logic                hit_iclr;
  logic                hit_ien;
  logic                mapped;   // Any register hit
  logic [31:0]         rd;       // Read mux
  logic [LCC_EV_N-1:0] ev;       // Events this cycle
  logic [LCC_EV_N-1:0] clr;      // Software clear mask

  // Address decode, word aligned
  assign hit_cap  = (paddr == LCC_OFS_CAP);
  assign hit_lcs  = (paddr == LCC_OFS_LCS);
  assign hit_ist  = (paddr == LCC_OFS_IST);
  assign hit_iclr = (paddr == LCC_OFS_ICLR);
  assign hit_ien  = (paddr == LCC_OFS_IEN);
  assign mapped   = hit_cap | hit_lcs | hit_ist | hit_iclr | hit_ien;

  // One wait state: pready rises in the second access cycle
  assign acc  = psel & penable & ~st_q.pready;
  assign done = psel & penable & st_q.pready;
  // Unmapped writes are dropped, the error answer says why
  assign wr   = done & pwrite & ~st_q.pslverr;

  // Read mux; fixed fields are constants so writes cannot reach them
  always_comb begin
    rd = 32'h0000_0000;
    if (hit_cap) begin
      // Port number fixed, width x1, speed 2.5 Gb/s
      rd = {LCC_PORT_NUM, 6'h00, st_q.cap.l1_lat, st_q.cap.l0s_lat,
            st_q.cap.aspm_sup, LCC_WIDTH_X1, LCC_SPEED_2G5};
    end else if (hit_lcs) begin
      // Slot clock, retrain, disable and completion bits read zero
      rd = {3'h0, 1'b0, st_q.ltrain, st_q.terr, st_q.width,
            LCC_SPEED_2G5, 8'h00, st_q.esync, st_q.cclk, 4'h0,
            st_q.aspm_ctl};
    end else if (hit_ist) begin
      rd = {29'h0000_0000, st_q.istat};
    end else if (hit_ien) begin
      rd = {29'h0000_0000, st_q.ien};
    end else begin
      // Clear register is write-only and reads zero
      rd = 32'h0000_0000;
    end
  end

  // Event sources for the sticky status bits
  always_comb begin
    ev = '0;
    ev[LCC_EV_TERR]  = train_fail;
    ev[LCC_EV_TDONE] = st_q.ltrain & ~train_active;
    ev[LCC_EV_LOAD]  = ee_load_valid;
  end

  // Software clear, only through the low byte lane
  assign clr = (wr & hit_iclr & pstrb[0]) ? pwdata[LCC_EV_N-1:0] : '0;

  // Next-state logic for the whole bank
  always_comb begin
    st_d = st_q;
    // Bus answer, built in the first access cycle
    st_d.pready  = acc;
    st_d.pslverr = acc & ~mapped;
    st_d.prdata  = (acc & mapped & ~pwrite) ? rd : 32'h0000_0000;

    // Autoload may replace defaults; software never can
    if (ee_load_valid) begin
      st_d.cap = ee_load;
    end

    // Control writes; the status half is read-only
    if (wr & hit_lcs & pstrb[0]) begin
      st_d.aspm_ctl = pwdata[1:0];
      st_d.cclk     = pwdata[LCC_CTL_CCLK];
      st_d.esync    = pwdata[LCC_CTL_ESYNC];
    end

    // Enable writes
    if (wr & hit_ien & pstrb[0]) begin
      st_d.ien = pwdata[LCC_EV_N-1:0];
    end

    // Training in progress mirrors the link layer
    st_d.ltrain = train_active;

    // A failure in the same cycle as L0 wins, so it is never lost
    if (train_fail) begin
      st_d.terr = 1'b1;
    end else if (link_l0) begin
      st_d.terr = 1'b0;
    end

    // Negotiated width is captured on reaching L0
    if (link_l0) begin
      st_d.width = neg_width;
    end

    // Sticky events: a new event beats a simultaneous clear
    st_d.istat = (st_q.istat & ~clr) | ev;

    // Level interrupt from the next status, so it stays a flop
    st_d.irq = |(st_d.istat & st_d.ien);

    // Receiver L0s does not depend on the control field
    st_d.rx_l0s_en = 1'b1;

    // Exit sequence counts follow the extended synch setting
    st_d.fts_cnt = st_d.esync ? LCC_FTS_EXT : LCC_FTS_NOM;
    st_d.ts1_cnt = st_d.esync ? LCC_TS1_EXT : LCC_TS1_NOM;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= LCC_ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign pready     = st_q.pready;
  assign pslverr    = st_q.pslverr;
  assign prdata     = st_q.prdata;
  assign tx_l0s_en  = st_q.aspm_ctl[0];
  assign tx_l1_en   = st_q.aspm_ctl[1];
  assign rx_l0s_en  = st_q.rx_l0s_en;
  assign common_clk = st_q.cclk;
  assign fts_count  = st_q.fts_cnt;
  assign ts1_count  = st_q.ts1_cnt;
  assign irq        = st_q.irq;

  // Checks on the bank's own outputs and register state
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Capability read answers carry the fixed speed code
  cap_speed_a: assert property (
    acc && hit_cap && !pwrite |=> prdata[3:0] == 4'h1)
    else $error("capability speed code wrong");

  // Capability width reads a single lane
  cap_width_a: assert property (
    acc && hit_cap && !pwrite |=> prdata[9:4] == 6'h01)
    else $error("capability width wrong");

  // Port number and reserved field read zero
  port_num_a: assert property (
    acc && hit_cap && !pwrite |=> prdata[31:18] == 14'h0000)
    else $error("port number not zero");

  // Unimplemented link bits stay zero on read
  ctl_zero_a: assert property (
    acc && hit_lcs && !pwrite |=> prdata[5:2] == 4'h0 &&
    prdata[28] == 1'b0 && prdata[15:8] == 8'h00)
    else $error("unimplemented link bit set");

  // Status speed field reads the fixed 2.5 Gb/s code
  sts_speed_a: assert property (
    acc && hit_lcs && !pwrite |=> prdata[19:16] == 4'h1)
    else $error("status speed code wrong");

  // Control write reaches the entry permits one edge later
  aspm_write_a: assert property (
    wr && hit_lcs && pstrb[0] |=> tx_l0s_en == $past(pwdata[0]) &&
    tx_l1_en == $past(pwdata[1]))
    else $error("entry control not applied");

  // Common clock follows a control write
  cclk_write_a: assert property (
    wr && hit_lcs && pstrb[0] |=> common_clk == $past(pwdata[6]))
    else $error("common clock not applied");

  // Receiver L0s stays permitted after reset
  rx_l0s_on_a: assert property (
    $past(presetn) |-> rx_l0s_en)
    else $error("receiver L0s blocked");

  // Extended synch selects the long sequence counts
  ext_synch_a: assert property (
    st_q.esync |-> fts_count == 13'h1000 && ts1_count == 11'h400)
    else $error("extended synch counts wrong");

  // Training failure raises the error bit next edge
  terr_set_a: assert property (
    train_fail |=> st_q.terr)
    else $error("training error not set");

  // Reaching L0 without failure clears the error bit
  terr_clr_a: assert property (
    link_l0 && !train_fail |=> !st_q.terr)
    else $error("training error not cleared");

  // Training bit tracks the link layer with one edge delay
  ltrain_a: assert property (
    train_active |=> st_q.ltrain ##1 (st_q.ltrain == $past(train_active)))
    else $error("training bit not tracking");

  // Negotiated width captured at L0
  width_cap_a: assert property (
    link_l0 |=> st_q.width == $past(neg_width))
    else $error("negotiated width not captured");

  // Autoload replaces the capability fields
  ee_load_a: assert property (
    ee_load_valid |=> st_q.cap == $past(ee_load))
    else $error("autoload not applied");

  // Software writes never change capability fields
  cap_ro_a: assert property (
    !ee_load_valid |=> $stable(st_q.cap))
    else $error("capability changed without autoload");

  // Interrupt level equals enabled sticky status
  irq_level_a: assert property (
    irq == |(st_q.istat & st_q.ien))
    else $error("interrupt level mismatch");

  // Every access is answered after exactly one wait state
  apb_answer_a: assert property (
    acc |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule

// file: verification/lcc_link_model.sv
// Link layer stand-in that drives the training strobes of the bank.
// Assumes a bench that pulses go with a run length and an outcome.
`timescale 1ns/1ps

module lcc_link_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,           // Start one training run
  input  wire logic       fail_req,     // Run ends in failure
  input  wire logic [3:0] len,          // Run length, at least 2
  input  wire logic [5:0] width_req,    // Lane count to report
  output logic            train_active,
  output logic            train_fail,
  output logic            link_l0,
  output logic [5:0]      neg_width
);
  logic [3:0] cnt_q; // Cycles left in the run

  // Width means nothing outside link_l0, so it churns every cycle
  // there; a design that samples it late sees garbage, not luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q        <= 4'h0;
      train_active <= 1'b0;
      train_fail   <= 1'b0;
      link_l0      <= 1'b0;
      neg_width    <= 6'h2A;
    end else begin
      train_fail <= 1'b0;
      link_l0    <= 1'b0;
      neg_width  <= ~neg_width;
      if (go && cnt_q == 4'h0) begin
        cnt_q        <= len;
        train_active <= 1'b1;
      end else if (cnt_q == 4'h1) begin
        // Outcome strobes on the cycle training ends
        cnt_q        <= 4'h0;
        train_active <= 1'b0;
        train_fail   <= fail_req;
        link_l0      <= !fail_req;
        if (!fail_req) begin
          neg_width <= width_req;
        end
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the link capability, control, status bank.
// Assumes the link model is compiled first; APB master is this bench.
`timescale 1ns/1ps

module testbench;
  import lcc_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ee_load_valid, train_active, train_fail, link_l0;
  logic        tx_l0s_en, tx_l1_en, rx_l0s_en, common_clk, irq;
  logic        go, fail_req, err, te_exp;
  logic [3:0]  pstrb, len;
  logic [5:0]  neg_width, width_req, w_exp;
  logic [7:0]  c_exp;      // Control byte last written
  logic [10:0] ts1_count;
  logic [11:0] paddr;
  logic [12:0] fts_count;
  logic [15:0] lfsr_q;     // Random source
  logic [31:0] pwdata, prdata, rd, d;
  lcc_ee_t     ee_load, ee_exp;
  int          failures, cmp_count;

  // 100 MHz core clock
  always #5 pclk = ~pclk;

  lcc_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ee_load_valid(ee_load_valid), .ee_load(ee_load),
    .train_active(train_active), .train_fail(train_fail),
    .link_l0(link_l0), .neg_width(neg_width), .tx_l0s_en(tx_l0s_en),
    .tx_l1_en(tx_l1_en), .rx_l0s_en(rx_l0s_en),
    .common_clk(common_clk), .fts_count(fts_count),
    .ts1_count(ts1_count), .irq(irq));

  lcc_link_model link_u (.pclk(pclk), .presetn(presetn), .go(go),
    .fail_req(fail_req), .len(len), .width_req(width_req),
    .train_active(train_active), .train_fail(train_fail),
    .link_l0(link_l0), .neg_width(neg_width));

  function automatic logic [15:0] lfsr_nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected capability word for given autoloadable fields
  function automatic logic [31:0] cap_exp(input lcc_ee_t c);
    return {8'h00, 6'h00, c.l1_lat, c.l0s_lat, c.aspm_sup, 6'h01, 4'h1};
  endfunction

  // Expected control/status word; only bits 7:6 and 1:0 hold writes
  function automatic logic [31:0] lcs_exp(input logic [7:0] c,
      input logic [5:0] w, input logic te, input logic tr);
    return {4'h0, tr, te, w, 4'h1, 8'h00, c & 8'hC3};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // One training run, checked mid-run and after it ends
  task automatic train(input logic f, input logic [5:0] w);
    int n;
    n = 0;
    lfsr_q = lfsr_nxt(lfsr_q);
    @(posedge pclk);
    go        <= 1'b1;
    fail_req  <= f;
    width_req <= w;
    len       <= {1'b1, lfsr_q[2:0]};
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
    rdchk(LCC_OFS_LCS, lcs_exp(c_exp, w_exp, te_exp, 1'b1));
    while (train_active === 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    // A run that never ends counts as a mismatch
    if (n >= 40) failures++;
    repeat (3) @(posedge pclk);
    te_exp = f;
    if (!f) w_exp = w;
    rdchk(LCC_OFS_LCS, lcs_exp(c_exp, w_exp, te_exp, 1'b0));
  endtask

  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'hF;
    ee_load_valid = 0; ee_load = 8'h00; go = 0; fail_req = 0;
    len = 4'h8; width_req = 6'h01; lfsr_q = 16'h20F1;
    failures = 0; cmp_count = 0; c_exp = 8'h00; te_exp = 0;
    w_exp = 6'h01; ee_exp = '{2'h3, 3'h3, 3'h0};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 chk(rx_l0s_en, 1'b1);
    rdchk(LCC_OFS_CAP, cap_exp(ee_exp));
    rdchk(LCC_OFS_LCS, lcs_exp(8'h00, 6'h01, 1'b0, 1'b0));
    apb(1'b1, LCC_OFS_CAP, 32'hFFFF_FFFF);
    rdchk(LCC_OFS_CAP, cap_exp(ee_exp));
    // Unmapped address is refused and reads zero
    apb(1'b0, 12'h0E0, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    // Every power-state code, with junk in reserved and status bits
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_nxt(lfsr_q);
      d = {lfsr_q, lfsr_q ^ 16'hA5A5};
      d[1:0] = i[1:0];
      d[6] = i[1];
      d[7] = i[0];
      apb(1'b1, LCC_OFS_LCS, d);
      c_exp = d[7:0];
      @(posedge pclk);
      #1 chk({tx_l1_en, tx_l0s_en}, i[1:0]);
      chk(common_clk, d[6]);
      chk(fts_count, d[7] ? 13'h1000 : 13'h0080);
      chk(ts1_count, d[7] ? 11'h400 : 11'h010);
      chk(rx_l0s_en, 1'b1);
      rdchk(LCC_OFS_LCS, lcs_exp(c_exp, w_exp, 1'b0, 1'b0));
    end
    // A write with byte 0 unstrobed is dropped
    pstrb <= 4'h0;
    apb(1'b1, LCC_OFS_LCS, 32'h0000_0000);
    pstrb <= 4'hF;
    rdchk(LCC_OFS_LCS, lcs_exp(c_exp, w_exp, 1'b0, 1'b0));
    // Autoload replaces the three capability fields
    lfsr_q = lfsr_nxt(lfsr_q);
    ee_exp = lcc_ee_t'(lfsr_q[7:0]);
    ee_load_valid <= 1'b1;
    ee_load       <= ee_exp;
    @(posedge pclk);
    ee_load_valid <= 1'b0;
    rdchk(LCC_OFS_CAP, cap_exp(ee_exp));
    // Only the autoload event has happened so far
    rdchk(LCC_OFS_IST, 32'h0000_0004);
    // Interrupt raised by a failed run, then masked and cleared
    apb(1'b1, LCC_OFS_ICLR, 32'h0000_0007);
    rdchk(LCC_OFS_IST, 32'h0000_0000);
    apb(1'b1, LCC_OFS_IEN, 32'h0000_0001);
    train(1'b1, 6'h01);
    chk(irq, 1'b1);
    rdchk(LCC_OFS_IST, 32'h0000_0003);
    apb(1'b1, LCC_OFS_IEN, 32'h0000_0000);
    rdchk(LCC_OFS_ICLR, 32'h0000_0000);
    chk(irq, 1'b0);
    apb(1'b1, LCC_OFS_ICLR, 32'h0000_0007);
    rdchk(LCC_OFS_IST, 32'h0000_0000);
    // Successful run clears the error and reports the new width
    train(1'b0, lfsr_q[13:8]);
    conclude();
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule
